// ### hdl/pcis_ctrl.sv
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// What this block does
// - stay idle-only while local receiver ok and remote receiver not ok
// - leave idle-only to idle-or-payload on remote ok, quiet on local loss
// - remote ok comes from peer scrambler choice; ours reports local status
// - idle-only keeps sending idle training with local status reported ok
// - peer silent: idle symbols at least 3,24 us, at most 1 ms, then zeros
// - on entering idle-or-payload the selector goes to normal data
// - management command or invalid symbol after link restarts training
// - transitions are the same in leader and follower role
module pcis_ctrl #(
  parameter int IDLE_MAX_CYC = pcis_pkg::IDLE_HOLD_MAX_CYC
) (
  input wire logic clock, // 200 MHz symbol clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire pcis_pkg::pcis_avs_req_t avs_req, // avalon request
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest, // avalon wait
  input wire logic rx_present_pin, // peer energy on pair, async
  input wire pcis_pkg::pcis_rx_t rx, // receiver status, same clock
  output pcis_pkg::pcis_sel_t tx_selector, // transmit mode
  output logic tx_scr_ok, // scrambler choice: local rx ok
  output logic irq // level interrupt
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [2:0] sync;
    logic present;
    pcis_pkg::pcis_state_t state;
    pcis_pkg::pcis_sel_t sel;
    logic [pcis_pkg::HOLD_W-1:0] hold_cnt;
    logic scr_ok;
    logic leader;
    logic [pcis_pkg::IRQ_N-1:0] irq_stat;
    logic [pcis_pkg::IRQ_N-1:0] irq_mask;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } pcis_regs_t;

  pcis_regs_t s_ff;
  pcis_regs_t nxt_s;

  function automatic pcis_pkg::pcis_reg_t reg_of(
    input logic [pcis_pkg::ADDR_W-1:0] a
  );
    unique case (a)
      pcis_pkg::OFS_CTRL: reg_of = pcis_pkg::REG_CTRL;
      pcis_pkg::OFS_STATUS: reg_of = pcis_pkg::REG_STATUS;
      pcis_pkg::OFS_IRQ_STAT: reg_of = pcis_pkg::REG_IRQ_STAT;
      pcis_pkg::OFS_IRQ_MASK: reg_of = pcis_pkg::REG_IRQ_MASK;
      default: reg_of = pcis_pkg::REG_NONE;
    endcase
  endfunction : reg_of

  function automatic pcis_pkg::pcis_sel_t sel_of(
    input pcis_pkg::pcis_state_t st
  );
    unique case (st)
      pcis_pkg::ST_DATA: sel_of = pcis_pkg::SEL_NORMAL;
      pcis_pkg::ST_QUIET: sel_of = pcis_pkg::SEL_ZEROS;
      pcis_pkg::ST_TRAIN, pcis_pkg::ST_IDLE: sel_of = pcis_pkg::SEL_IDLE;
    endcase
  endfunction : sel_of

  logic rem_ok;
  logic lost;
  logic wr_ack;
  logic restart;
  pcis_pkg::pcis_reg_t rsel;
  logic [pcis_pkg::IRQ_N-1:0] ev;

  // scrambler status trusted only while the synced pin says the peer talks
  assign rem_ok = rx.scr_ok & s_ff.present;
  assign lost = ~rx.local_ok | ~s_ff.present;
  assign rsel = reg_of(avs_req.address);
  // a write lands only at the edge where waitrequest is seen low
  assign wr_ack = avs_req.write & ~s_ff.waitreq & avs_req.byteenable[0];
  assign restart = wr_ack & (rsel == pcis_pkg::REG_CTRL)
    & avs_req.writedata[pcis_pkg::CTRL_RESTART_BIT];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_s = s_ff;
    ev = '0;
    // peer presence: three flops, change accepted when last two agree
    nxt_s.sync = {s_ff.sync[1:0], rx_present_pin};
    if (s_ff.sync[1] == s_ff.sync[2]) begin
      nxt_s.present = s_ff.sync[2];
    end

    // leader/follower only reported; the paths below ignore it
    unique case (s_ff.state)
      pcis_pkg::ST_TRAIN: begin
        nxt_s.hold_cnt = '0;
        if (rx.train_done && rx.local_ok) begin
          nxt_s.state = pcis_pkg::ST_IDLE;
        end
      end
      pcis_pkg::ST_IDLE: begin
        if (restart || rx.invalid_sym) begin
          nxt_s.state = pcis_pkg::ST_TRAIN;
          ev[pcis_pkg::IRQ_RESTART_BIT] = 1'b1;
        end else if (lost) begin
          // keep idle symbols for the least hold before going quiet
          if (s_ff.hold_cnt == pcis_pkg::HOLD_LAST) begin
            nxt_s.state = pcis_pkg::ST_QUIET;
            ev[pcis_pkg::IRQ_QUIET_BIT] = 1'b1;
          end else begin
            nxt_s.hold_cnt = s_ff.hold_cnt + 1'b1;
          end
        end else if (rem_ok) begin
          nxt_s.state = pcis_pkg::ST_DATA;
          ev[pcis_pkg::IRQ_LINK_UP_BIT] = 1'b1;
        end else begin
          nxt_s.hold_cnt = '0;
        end
      end
      pcis_pkg::ST_DATA: begin
        nxt_s.hold_cnt = '0;
        if (restart || rx.invalid_sym) begin
          nxt_s.state = pcis_pkg::ST_TRAIN;
          ev[pcis_pkg::IRQ_RESTART_BIT] = 1'b1;
        end else if (!rx.local_ok) begin
          nxt_s.state = pcis_pkg::ST_QUIET;
          ev[pcis_pkg::IRQ_QUIET_BIT] = 1'b1;
        end else if (!rem_ok) begin
          nxt_s.state = pcis_pkg::ST_IDLE;
        end
      end
      pcis_pkg::ST_QUIET: begin
        nxt_s.hold_cnt = '0;
        // peer back on the pair: retrain from scratch
        if (restart || s_ff.present) begin
          nxt_s.state = pcis_pkg::ST_TRAIN;
          ev[pcis_pkg::IRQ_RESTART_BIT] = 1'b1;
        end
      end
    endcase
    nxt_s.sel = sel_of(nxt_s.state);
    // our scrambler reports local ok once out of training
    nxt_s.scr_ok = rx.local_ok && (nxt_s.state != pcis_pkg::ST_TRAIN);

    // ************************************************************
    // register bus
    // ************************************************************
    // one wait cycle per access; wait drops for exactly one edge
    if ((avs_req.read || avs_req.write) && s_ff.waitreq) begin
      nxt_s.waitreq = 1'b0;
    end else begin
      nxt_s.waitreq = 1'b1;
    end
    if (avs_req.read && s_ff.waitreq) begin
      nxt_s.rdata = '0;
      unique case (rsel)
        pcis_pkg::REG_CTRL:
          nxt_s.rdata[pcis_pkg::CTRL_LEADER_BIT] = s_ff.leader;
        pcis_pkg::REG_STATUS: begin
          nxt_s.rdata[pcis_pkg::STAT_STATE_LSB +: 2] = s_ff.state;
          nxt_s.rdata[pcis_pkg::STAT_SEL_LSB +: 2] = s_ff.sel;
          nxt_s.rdata[pcis_pkg::STAT_LOC_OK_BIT] = rx.local_ok;
          nxt_s.rdata[pcis_pkg::STAT_REM_OK_BIT] = rem_ok;
          nxt_s.rdata[pcis_pkg::STAT_PRESENT_BIT] = s_ff.present;
          nxt_s.rdata[pcis_pkg::STAT_LEADER_BIT] = s_ff.leader;
        end
        pcis_pkg::REG_IRQ_STAT:
          nxt_s.rdata[pcis_pkg::IRQ_N-1:0] = s_ff.irq_stat;
        pcis_pkg::REG_IRQ_MASK:
          nxt_s.rdata[pcis_pkg::IRQ_N-1:0] = s_ff.irq_mask;
        pcis_pkg::REG_NONE: nxt_s.rdata = '0;
        default: nxt_s.rdata = '0;
      endcase
    end
    if (wr_ack && rsel == pcis_pkg::REG_CTRL) begin
      nxt_s.leader = avs_req.writedata[pcis_pkg::CTRL_LEADER_BIT];
    end
    if (wr_ack && rsel == pcis_pkg::REG_IRQ_MASK) begin
      nxt_s.irq_mask = avs_req.writedata[pcis_pkg::IRQ_N-1:0];
    end
    // write one to clear; a same-cycle event wins
    for (int i = 0; i < pcis_pkg::IRQ_N; i++) begin
      if (ev[i]) begin
        nxt_s.irq_stat[i] = 1'b1;
      end else if (wr_ack && rsel == pcis_pkg::REG_IRQ_STAT
                   && avs_req.writedata[i]) begin
        nxt_s.irq_stat[i] = 1'b0;
      end
    end
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '{sync: 3'h0, present: 1'h0, state: pcis_pkg::ST_TRAIN,
                sel: pcis_pkg::SEL_IDLE, hold_cnt: '0, scr_ok: 1'h0,
                leader: pcis_pkg::CTRL_LEADER_RST, irq_stat: '0,
                irq_mask: pcis_pkg::IRQ_MASK_RST, irq: 1'h0,
                waitreq: 1'h1, rdata: 32'h0};
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign tx_selector = s_ff.sel;
  assign tx_scr_ok = s_ff.scr_ok;
  assign irq = s_ff.irq;
  assign avs_readdata = s_ff.rdata;
  assign avs_waitrequest = s_ff.waitreq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic step;
  assign step = clk_en & ~restart & ~rx.invalid_sym;

  stay_idle_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && step && !lost && !rem_ok
    |=> s_ff.state == pcis_pkg::ST_IDLE && s_ff.hold_cnt == '0)
    else $error("left idle-only without cause");
  go_data_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && step && !lost && rem_ok
    |=> s_ff.state == pcis_pkg::ST_DATA)
    else $error("remote ok did not reach idle-or-payload");
  scr_report_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && clk_en && rx.local_ok
    && !rx.invalid_sym && !restart |=> tx_scr_ok)
    else $error("local ok not reported in scrambler choice");
  idle_sel_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE |-> tx_selector == pcis_pkg::SEL_IDLE)
    else $error("idle-only not sending idle symbols");
  hold_min_a: assert property (
    $rose(tx_selector == pcis_pkg::SEL_ZEROS)
    && $past(s_ff.state) == pcis_pkg::ST_IDLE
    |-> $past(s_ff.hold_cnt) == pcis_pkg::HOLD_LAST)
    else $error("zeros before least idle hold");
  hold_max_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && lost && step
    && s_ff.hold_cnt == pcis_pkg::HOLD_LAST
    |=> tx_selector == pcis_pkg::SEL_ZEROS
    && int'(s_ff.hold_cnt) < IDLE_MAX_CYC)
    else $error("idle hold overran");
  data_sel_a: assert property (
    $rose(s_ff.state == pcis_pkg::ST_DATA)
    |-> tx_selector == pcis_pkg::SEL_NORMAL)
    else $error("idle-or-payload without normal data");
  retrain_a: assert property (
    s_ff.state == pcis_pkg::ST_DATA && clk_en && (restart || rx.invalid_sym)
    |=> s_ff.state == pcis_pkg::ST_TRAIN
    && s_ff.irq_stat[pcis_pkg::IRQ_RESTART_BIT])
    else $error("restart not honoured");
  role_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && step && !lost && rem_ok
    && !s_ff.leader |=> s_ff.state == pcis_pkg::ST_DATA)
    else $error("follower path differs");
  sel_match_a: assert property (
    tx_selector == sel_of(s_ff.state) && tx_selector != 2'h3)
    else $error("selector out of step with state");
  bus_ack_a: assert property (
    (avs_req.read || avs_req.write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  irq_level_a: assert property (
    irq == |(s_ff.irq_stat & s_ff.irq_mask))
    else $error("interrupt out of step with status");
  lost_count_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && step && lost
    && s_ff.hold_cnt != pcis_pkg::HOLD_LAST
    |=> s_ff.state == pcis_pkg::ST_IDLE
    && s_ff.hold_cnt == $past(s_ff.hold_cnt) + 1'b1)
    else $error("lost cycle not counted");
  quiet_irq_a: assert property (
    s_ff.state == pcis_pkg::ST_IDLE && step && lost
    && s_ff.hold_cnt == pcis_pkg::HOLD_LAST
    |=> s_ff.irq_stat[pcis_pkg::IRQ_QUIET_BIT])
    else $error("quiet entry not flagged");
  // a clear in the same cycle must never swallow an event
  set_wins_a: assert property (
    clk_en && |ev |=> (s_ff.irq_stat & $past(ev)) == $past(ev))
    else $error("event lost against a clear");
  // waitrequest low for one edge, never two in a row
  wait_once_a: assert property (
    !avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // clock enable low must hold every flop, the bus included
  freeze_a: assert property (
    !clk_en |=> $stable(s_ff))
    else $error("state moved while frozen");

  link_up_c: cover property (
    s_ff.state == pcis_pkg::ST_IDLE ##1 s_ff.state == pcis_pkg::ST_DATA);
  quiet_c: cover property (
    s_ff.state == pcis_pkg::ST_IDLE ##1 s_ff.state == pcis_pkg::ST_QUIET);
  retrain_c: cover property (
    s_ff.state == pcis_pkg::ST_DATA ##1 s_ff.state == pcis_pkg::ST_TRAIN);
  irq_c: cover property (irq && avs_req.read && !avs_waitrequest);
  freeze_c: cover property (!clk_en && rx.invalid_sym);

endmodule : pcis_ctrl

// ### pkg/pcis_pkg.sv
package pcis_pkg;

  // ************************************************************
  // control states and transmit selector
  // ************************************************************
  typedef enum logic [1:0] {
    ST_TRAIN,
    ST_IDLE,
    ST_DATA,
    ST_QUIET
  } pcis_state_t;

  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_NORMAL,
    SEL_ZEROS
  } pcis_sel_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int IDLE_HOLD_MIN_NS = 3240;
  localparam int IDLE_HOLD_MAX_NS = 1000000;
  // least time rounds up, longest rounds down
  localparam int IDLE_HOLD_MIN_CYC =
    (IDLE_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_HOLD_MAX_CYC = IDLE_HOLD_MAX_NS / CLK_PERIOD_NS;
  localparam int HOLD_W = 10;
  localparam logic [HOLD_W-1:0] HOLD_LAST =
    HOLD_W'(IDLE_HOLD_MIN_CYC - 1);

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_STATUS,
    REG_IRQ_STAT,
    REG_IRQ_MASK,
    REG_NONE
  } pcis_reg_t;

  // ctrl fields
  localparam int CTRL_LEADER_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic CTRL_LEADER_RST = 1'h1;

  // status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SEL_LSB = 2;
  localparam int STAT_LOC_OK_BIT = 4;
  localparam int STAT_REM_OK_BIT = 5;
  localparam int STAT_PRESENT_BIT = 6;
  localparam int STAT_LEADER_BIT = 7;

  // interrupt events
  localparam int IRQ_N = 3;
  localparam int IRQ_LINK_UP_BIT = 0;
  localparam int IRQ_QUIET_BIT = 1;
  localparam int IRQ_RESTART_BIT = 2;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 3'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pcis_avs_req_t;

  typedef struct packed {
    logic local_ok;
    logic scr_ok;
    logic invalid_sym;
    logic train_done;
  } pcis_rx_t;

endpackage : pcis_pkg

// ### bench/pcis_peer.sv
`timescale 1ns/1ps
module pcis_peer #(
  parameter int HOLD_CYC = 16
) (
  input wire logic clock, // symbol clock
  input wire logic resetn, // async reset, active low
  input wire logic talk, // peer transmits on the pair
  input wire logic rcv_ok, // peer's own receiver state
  input wire logic bad, // peer sends invalid symbols
  output logic present_pin, // energy seen by the device
  output logic scr_ok, // peer scrambler choice as received
  output logic invalid_sym // invalid symbol as received
);
  // ****************************************
  // peer scrambler choice
  // ****************************************
  logic [7:0] held_ff;
  logic sent_ok_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      held_ff <= 8'h0;
      sent_ok_ff <= 1'b0;
    end else begin
      if (!talk) begin
        held_ff <= 8'h0;
        sent_ok_ff <= 1'b0;
      end else if (sent_ok_ff && !rcv_ok) begin
        held_ff <= 8'h0;
        sent_ok_ff <= 1'b0;
      end else if (!sent_ok_ff) begin
        if (rcv_ok && held_ff >= 8'(HOLD_CYC)) begin
          sent_ok_ff <= 1'b1;
        end else if (held_ff != 8'hff) begin
          held_ff <= held_ff + 8'h1;
        end
      end
    end
  end

  assign present_pin = talk;
  // no signal, no descrambler lock: a silent pair decodes as not ok
  assign scr_ok = talk & sent_ok_ff;
  assign invalid_sym = talk & bad;
endmodule : pcis_peer

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // design, peer and helpers
  // ****************************************
  localparam int IDLE_MAX = 1000;
  localparam int MIN_HOLD = pcis_pkg::IDLE_HOLD_MIN_CYC;
  logic clock = 1'b0;
  logic resetn, clk_en, rx_present_pin, scr_ok, inv;
  logic local_ok, train_done, talk, rcv_ok, bad, tx_scr_ok, irq;
  pcis_pkg::pcis_avs_req_t avs_req;
  pcis_pkg::pcis_rx_t rx;
  pcis_pkg::pcis_sel_t tx_selector;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;

  always #2.5 clock = ~clock;
  assign rx = {local_ok, scr_ok, inv, train_done};

  pcis_ctrl #(.IDLE_MAX_CYC(IDLE_MAX)) dut_u (.clock(clock),
    .resetn(resetn), .clk_en(clk_en), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_present_pin(rx_present_pin), .rx(rx), .tx_selector(tx_selector),
    .tx_scr_ok(tx_scr_ok), .irq(irq));
  pcis_peer #(.HOLD_CYC(16)) peer_u (.clock(clock), .resetn(resetn),
    .talk(talk), .rcv_ok(rcv_ok), .bad(bad), .present_pin(rx_present_pin),
    .scr_ok(scr_ok), .invalid_sym(inv));

  function automatic logic [31:0] stat_exp(input logic [1:0] st,
    input logic [1:0] sel, input logic lo, re, pr, ld);
    return {24'h0, ld, pr, re, lo, sel, st};
  endfunction : stat_exp

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int w;
    w = 0;
    avs_req <= '{address: a, read: !wr, write: wr, writedata: d,
      byteenable: 4'hf};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && w < 100) begin
      @(posedge clock);
      w++;
    end
    q = avs_readdata;
    chk("bus ack", 32'h0, 32'(w == 100));
    avs_req <= '0;
    @(posedge clock);
  endtask : bus

  task automatic wait_sel(input int lim);
    n = 0;
    while (tx_selector === pcis_pkg::SEL_IDLE && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_sel

  task automatic bring_idle;
    talk <= 1'b1;
    local_ok <= 1'b1;
    train_done <= 1'b1;
    rcv_ok <= 1'b0;
    for (int k = 0; k < 200 && tx_scr_ok !== 1'b1; k++) @(posedge clock);
    chk("scr ok", 32'h1, {31'h0, tx_scr_ok});
  endtask : bring_idle

  task automatic idle_for(input int c);
    repeat (c) begin
      @(posedge clock);
      chk("idle out", 32'h1, {29'h0, tx_selector, tx_scr_ok});
    end
  endtask : idle_for

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    avs_req = '0;
    {local_ok, train_done, talk, rcv_ok, bad} = 5'h0;
    void'($urandom(41835));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("reset out", 32'h0, {28'h0, tx_selector, tx_scr_ok, irq});
    bus(0, pcis_pkg::OFS_STATUS, 32'h0);
    chk("status", stat_exp(0, 0, 0, 0, 0, 1), q);
    bus(1, 4'h2, 32'hff);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    n = $urandom;
    bus(1, pcis_pkg::OFS_IRQ_MASK, 32'(n));
    bus(0, pcis_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'(n) & 32'((1 << pcis_pkg::IRQ_N) - 1), q);
    for (int r = 1; r >= 0; r--) begin
      bus(1, pcis_pkg::OFS_CTRL, 32'(r));
      bring_idle;
      idle_for(16 + ($urandom % 200));
      bus(1, pcis_pkg::OFS_IRQ_STAT, 32'h7);
      bus(1, pcis_pkg::OFS_IRQ_MASK, 32'h0);
      rcv_ok <= 1'b1;
      wait_sel(200);
      chk("sel", 32'(pcis_pkg::SEL_NORMAL), {30'h0, tx_selector});
      bus(0, pcis_pkg::OFS_STATUS, 32'h0);
      chk("status", stat_exp(2, 1, 1, 1, 1, r[0]), q);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1, pcis_pkg::OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clock);
      chk("irq", 32'h1, {31'h0, irq});
      bus(0, pcis_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h1, q);
      bus(1, pcis_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clock);
      chk("irq clear", 32'h0, {31'h0, irq});
      // invalid symbols while frozen must not restart training
      clk_en <= 1'b0;
      bad <= 1'b1;
      repeat (4) begin
        @(posedge clock);
        chk("frozen", 32'(pcis_pkg::SEL_NORMAL), {30'h0, tx_selector});
      end
      clk_en <= 1'b1;
      bad <= 1'b0;
      repeat (2) @(posedge clock);
      chk("thawed", 32'(pcis_pkg::SEL_NORMAL), {30'h0, tx_selector});
      rcv_ok <= 1'b0;
      train_done <= 1'b0;
      if (r == 1) begin
        bad <= 1'b1;
        @(posedge clock);
        bad <= 1'b0;
      end else bus(1, pcis_pkg::OFS_CTRL, 32'h2);
      repeat (4) @(posedge clock);
      bus(0, pcis_pkg::OFS_STATUS, 32'h0);
      chk("restart", stat_exp(0, 0, 1, 0, 1, r[0]), q);
      bus(0, pcis_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h4, q);
      bus(1, pcis_pkg::OFS_IRQ_STAT, 32'h7);
      bring_idle;
      // short outage must not leave idle-only
      talk <= 1'b0;
      idle_for(1 + ($urandom % 500));
      talk <= 1'b1;
      idle_for(20);
      if (r == 1) talk <= 1'b0;
      else local_ok <= 1'b0;
      wait_sel(2000);
      chk("hold", 32'h1, {31'h0, n > MIN_HOLD && n <= IDLE_MAX});
      chk("sel", 32'(pcis_pkg::SEL_ZEROS), {30'h0, tx_selector});
      bus(0, pcis_pkg::OFS_STATUS, 32'h0);
      chk("quiet", stat_exp(r ? 3 : 0, r ? 2 : 0, r[0], 0, !r[0], r[0]),
        q);
      bus(0, pcis_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h2, q & 32'h2);
      local_ok <= 1'b1;
      talk <= 1'b1;
      bus(1, pcis_pkg::OFS_IRQ_STAT, 32'h7);
    end
    end_of_test;
  end
endmodule : testbench
